// ---- pod_link_model.sv ----
// Link-layer controller model that issues register writes and reads to the bank.
`timescale 1ns/1ps
module pod_link_model
    import pod_pkg::*;
(
    // Clock
    input  wire logic       core_clk,
    // Register port toward the bank
    output logic      [7:0] reg_addr,
    output logic      [7:0] reg_wdata,
    output logic            reg_wr,
    output logic            reg_rd,
    input  wire logic [7:0] reg_rdata
);
    initial begin
        reg_addr  = POD_ZERO;
        reg_wdata = POD_ZERO;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
    end

    // The idle cycle after a write keeps a following write from raising the strobe in the same step.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge core_clk);
        reg_wr    <= 1'b0;
        @(posedge core_clk);
    endtask : wr

    // Read data stands only in the cycle after the strobe, so it is taken at the edge ending that cycle.
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge core_clk);
        reg_rd   <= 1'b0;
        @(posedge core_clk);
        d = reg_rdata;
    endtask : rd
endmodule : pod_link_model

// ---- pod_pkg.sv ----
// Package of offsets, field positions and reset values for the line pull-down and detach interrupt register bank.
package pod_pkg;

    localparam int          POD_AW            = 8;
    localparam int          POD_DW            = 8;

    // Base offsets; pull-down, enables and scratch write at base, set at base plus one, clear at base plus two; status, latch, debug single.
    localparam logic [7:0]  POD_PULLDOWN_OFS  = 8'h0A;
    localparam logic [7:0]  POD_RISE_EN_OFS   = 8'h0D;
    localparam logic [7:0]  POD_FALL_EN_OFS   = 8'h10;
    localparam logic [7:0]  POD_STATUS_OFS    = 8'h13;
    localparam logic [7:0]  POD_LATCH_OFS     = 8'h14;
    localparam logic [7:0]  POD_DEBUG_OFS     = 8'h15;
    localparam logic [7:0]  POD_SCRATCH_OFS   = 8'h16;
    localparam logic [7:0]  POD_SET_STEP      = 8'h01;
    localparam logic [7:0]  POD_CLR_STEP      = 8'h02;

    // Field positions.
    localparam int          POD_POS_PD_BIT    = 1;
    localparam int          POD_NEG_PD_BIT    = 2;
    localparam int          POD_DETACH_BIT    = 0;

    // Implemented-bit masks.
    localparam logic [7:0]  POD_PULLDOWN_MASK = 8'h06;
    localparam logic [7:0]  POD_EN_MASK       = 8'h01;
    localparam logic [7:0]  POD_SCRATCH_MASK  = 8'hFF;
    localparam logic [7:0]  POD_DEBUG_MASK    = 8'h03;

    // Reset values.
    localparam logic [7:0]  POD_PULLDOWN_RST  = 8'h06;
    localparam logic [7:0]  POD_RISE_EN_RST   = 8'h01;
    localparam logic [7:0]  POD_FALL_EN_RST   = 8'h01;
    localparam logic [7:0]  POD_SCRATCH_RST   = 8'h00;
    localparam logic [7:0]  POD_ZERO          = 8'h00;

    // Synchroniser depth for pin inputs.
    localparam int          POD_SYNC_STAGES   = 2;

endpackage : pod_pkg

// ---- pod_regs.sv ----
// Byte register bank for line pull-downs, detach interrupt enables, status, latch, debug and scratch.
//
// What this block does
// - Pull-down control readable at three addresses; write, set, clear at each respectively.
// - Bit 1 drives the positive line pull-down; resets to one.
// - Bit 2 drives the negative line pull-down; resets to one.
// - Pull-down control bits 0 and 7 to 3 always read zero.
// - Rising-enable bit 0 allows detach low-to-high events; write/set/clear addresses; resets one.
// - Detach events count only in host mode, both pull-downs enabled.
// - Falling-enable bit 0 allows detach high-to-low events; write/set/clear addresses; resets one.
// - Read-only status register shows detach condition in bit 0.
// - Latch bit 0 sets on every enabled detach transition in host mode.
// - Latch register is read-only and clears itself when read, unless an enabled detach event arrives in the same cycle.
// - Debug register shows current two-bit line state; upper bits read zero.
// - Scratch byte supports read, write, set, clear; resets zero; no side effects.
// - Scratch readable at three addresses: write first, set second, clear third.
`timescale 1ns/1ps
module pod_regs
    import pod_pkg::*;
(
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        nrst,
    // Register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [7:0]  reg_rdata,
    // Pin inputs from the analog front end
    input  wire logic        far_detach_in,
    input  wire logic [1:0]  line_level_in,
    // Pull-down controls and latched event
    output logic             pos_line_pulldown_en,
    output logic             neg_line_pulldown_en,
    output logic             detach_irq_latched
);

    logic [7:0] pulldown_r;
    logic [7:0] rise_en_r;
    logic [7:0] fall_en_r;
    logic [7:0] scratch_r;
    logic       latch_r;
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;
    logic [7:0] status_val;
    logic [7:0] debug_val;
    logic       detach_lvl;
    logic       detach_rise;
    logic       detach_fall;
    logic [1:0] line_lvl;
    logic       line_level_bit0;
    logic       line_level_bit1;
    logic       host_mode;
    logic       detach_event;
    logic       latch_read;

    // Register update: write replaces, set ORs, clear removes; unimplemented bits masked away.
    function automatic logic [7:0] pod_wsc(input logic [7:0] cur,
                                           input logic [7:0] base,
                                           input logic [7:0] addr,
                                           input logic [7:0] wd,
                                           input logic [7:0] mask);
        logic [7:0] res;
        res = cur;
        if (addr == base) begin
            res = wd;
        end else if (addr == base + POD_SET_STEP) begin
            res = cur | wd;
        end else if (addr == base + POD_CLR_STEP) begin
            res = cur & ~wd;
        end
        return res & mask;
    endfunction : pod_wsc

    // Read hits any of the three aliases of a write/set/clear register.
    function automatic logic pod_hit3(input logic [7:0] addr, input logic [7:0] base);
        return (addr >= base) && (addr <= base + POD_CLR_STEP);
    endfunction : pod_hit3

    pod_sync_edge #(
        .WIDTH (1)
    ) u_detach_sync (
        .core_clk (core_clk),
        .nrst     (nrst),
        .async_in (far_detach_in),
        .level    (detach_lvl),
        .rise     (detach_rise),
        .fall     (detach_fall)
    );

    pod_sync_edge #(
        .WIDTH (2)
    ) u_line_sync (
        .core_clk (core_clk),
        .nrst     (nrst),
        .async_in (line_level_in),
        .level    (line_lvl),
        .rise     (),
        .fall     ()
    );

    assign line_level_bit0 = line_lvl[0];
    assign line_level_bit1 = line_lvl[1];

    assign host_mode = pulldown_r[POD_POS_PD_BIT] & pulldown_r[POD_NEG_PD_BIT];

    assign detach_event = host_mode &
                          ((detach_rise & rise_en_r[POD_DETACH_BIT]) |
                           (detach_fall & fall_en_r[POD_DETACH_BIT]));

    assign latch_read = reg_rd && (reg_addr == POD_LATCH_OFS);

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            pulldown_r <= POD_PULLDOWN_RST;
        end else if (reg_wr) begin
            pulldown_r <= pod_wsc(pulldown_r, POD_PULLDOWN_OFS, reg_addr, reg_wdata, POD_PULLDOWN_MASK);
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            rise_en_r <= POD_RISE_EN_RST;
        end else if (reg_wr) begin
            rise_en_r <= pod_wsc(rise_en_r, POD_RISE_EN_OFS, reg_addr, reg_wdata, POD_EN_MASK);
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            fall_en_r <= POD_FALL_EN_RST;
        end else if (reg_wr) begin
            fall_en_r <= pod_wsc(fall_en_r, POD_FALL_EN_OFS, reg_addr, reg_wdata, POD_EN_MASK);
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            scratch_r <= POD_SCRATCH_RST;
        end else if (reg_wr) begin
            scratch_r <= pod_wsc(scratch_r, POD_SCRATCH_OFS, reg_addr, reg_wdata, POD_SCRATCH_MASK);
        end
    end

    // latch set, clear on read.
    // A new event in the reading cycle wins, so it is reported by the next read instead of lost.
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            latch_r <= 1'b0;
        end else if (detach_event) begin
            latch_r <= 1'b1;
        end else if (latch_read) begin
            latch_r <= 1'b0;
        end
    end

    assign status_val = {7'h00, detach_lvl & host_mode};
    assign debug_val  = {6'h00, line_level_bit1, line_level_bit0} & POD_DEBUG_MASK;

    // Read mux; unmapped addresses read as zero.
    always_comb begin
        rdata_nxt = POD_ZERO;
        if (pod_hit3(reg_addr, POD_PULLDOWN_OFS)) begin
            rdata_nxt = pulldown_r & POD_PULLDOWN_MASK;
        end else if (pod_hit3(reg_addr, POD_RISE_EN_OFS)) begin
            rdata_nxt = rise_en_r;
        end else if (pod_hit3(reg_addr, POD_FALL_EN_OFS)) begin
            rdata_nxt = fall_en_r;
        end else if (reg_addr == POD_STATUS_OFS) begin
            rdata_nxt = status_val;
        end else if (reg_addr == POD_LATCH_OFS) begin
            rdata_nxt = {7'h00, latch_r};
        end else if (reg_addr == POD_DEBUG_OFS) begin
            rdata_nxt = debug_val;
        end else if (pod_hit3(reg_addr, POD_SCRATCH_OFS)) begin
            rdata_nxt = scratch_r;
        end
    end

    // Read data stand only in the cycle after the strobe and are zero otherwise.
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            rdata_r <= POD_ZERO;
        end else if (reg_rd) begin
            rdata_r <= rdata_nxt;
        end else begin
            rdata_r <= POD_ZERO;
        end
    end

    assign reg_rdata            = rdata_r;
    assign pos_line_pulldown_en = pulldown_r[POD_POS_PD_BIT];
    assign neg_line_pulldown_en = pulldown_r[POD_NEG_PD_BIT];
    assign detach_irq_latched   = latch_r;

    // Assertions on the register bank and the detach latch.
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!nrst);

    sequence s_wr(logic [7:0] a);
        reg_wr && (reg_addr == a);
    endsequence

    sequence s_rd(logic [7:0] a);
        reg_rd && (reg_addr == a);
    endsequence

    // A scratch write, one idle bus cycle, then a read at the clear alias.
    sequence s_scratch_wr_rd;
        s_wr(8'h16) ##1 !reg_wr ##1 s_rd(8'h18);
    endsequence

    sequence s_scratch_wr;
        reg_wr && (reg_addr >= 8'h16) && (reg_addr <= 8'h18);
    endsequence

    pulldown_set_a: assert property (s_wr(8'h0B) |=> pulldown_r == (($past(pulldown_r) | $past(reg_wdata)) & 8'h06))
        else $error("Pull-down set write did not OR in the data.");

    pos_pulldown_a: assert property (s_wr(8'h0A) |=> pos_line_pulldown_en == $past(reg_wdata[1]))
        else $error("Positive pull-down does not follow written bit 1.");

    neg_pulldown_clr_a: assert property (s_wr(8'h0C) ##0 reg_wdata[2] |=> !neg_line_pulldown_en)
        else $error("Negative pull-down not cleared by clear write.");

    pulldown_reserved_a: assert property (reg_rd && reg_addr >= 8'h0A && reg_addr <= 8'h0C
                                          |=> reg_rdata[7:3] == 5'h00 && !reg_rdata[0])
        else $error("Pull-down reserved bits read nonzero.");

    rise_event_a: assert property (detach_rise && rise_en_r[0] && host_mode |=> latch_r)
        else $error("Enabled rising detach edge did not set the latch.");

    host_gate_a: assert property ($rose(latch_r) |-> $past(host_mode))
        else $error("Latch set outside host mode.");

    fall_event_a: assert property (detach_fall && fall_en_r[0] && host_mode |=> latch_r)
        else $error("Enabled falling detach edge did not set the latch.");

    status_read_a: assert property (s_rd(8'h13) |=> reg_rdata == {7'h00, $past(detach_lvl & host_mode)})
        else $error("Status read does not show detach condition.");

    latch_cause_a: assert property ($rose(latch_r) |-> $past(detach_event))
        else $error("Latch set without an enabled detach event.");

    latch_clear_a: assert property (s_rd(8'h14) ##0 !detach_event |=> !latch_r ##0 reg_rdata[0] == $past(latch_r))
        else $error("Latch read did not report and clear.");

    debug_read_a: assert property (s_rd(8'h15) |=> reg_rdata == {6'h00, $past(line_lvl)})
        else $error("Debug read does not show line state.");

    scratch_rw_a: assert property (s_scratch_wr_rd |=> reg_rdata == $past(reg_wdata, 3))
        else $error("Scratch write not returned by read.");

    scratch_clr_a: assert property (s_wr(8'h18) |=> scratch_r == ($past(scratch_r) & ~$past(reg_wdata)))
        else $error("Scratch clear write wrong.");

    idle_rdata_a: assert property (!reg_rd |=> reg_rdata == 8'h00)
        else $error("Read data present without a read strobe.");

    pulldown_write_a: assert property (s_wr(8'h0A) |=> pulldown_r == ($past(reg_wdata) & 8'h06))
        else $error("Pull-down write did not replace the value.");

    pulldown_clear_a: assert property (s_wr(8'h0C) |=> pulldown_r == ($past(pulldown_r) & ~$past(reg_wdata)))
        else $error("Pull-down clear write wrong.");

    neg_pulldown_set_a: assert property (s_wr(8'h0B) ##0 reg_wdata[2] |=> neg_line_pulldown_en)
        else $error("Negative pull-down not set by set write.");

    pd_fields_a: assert property (pulldown_r[0] == 1'b0 && pulldown_r[7:3] == 5'h00)
        else $error("Unimplemented pull-down bits hold ones.");

    rise_en_clear_a: assert property (s_wr(8'h0F) |=> rise_en_r == ($past(rise_en_r) & ~$past(reg_wdata)))
        else $error("Rising enable clear write wrong.");

    rise_en_read_a: assert property (s_rd(8'h0E) |=> reg_rdata == $past(rise_en_r))
        else $error("Rising enable alias read wrong.");

    fall_set_a: assert property (s_wr(8'h11) |=> fall_en_r == (($past(fall_en_r) | $past(reg_wdata)) & 8'h01))
        else $error("Falling enable set write wrong.");

    fall_en_read_a: assert property (s_rd(8'h12) |=> reg_rdata == $past(fall_en_r))
        else $error("Falling enable alias read wrong.");

    latch_hold_a: assert property (latch_r && !latch_read |=> latch_r)
        else $error("Latch dropped without a latch read.");

    set_wins_a: assert property (s_rd(8'h14) ##0 detach_event |=> latch_r && reg_rdata[0] == $past(latch_r))
        else $error("Event during a latch read was lost.");

    scratch_set_a: assert property (s_wr(8'h17) |=> scratch_r == ($past(scratch_r) | $past(reg_wdata)))
        else $error("Scratch set write wrong.");

    scratch_alias_a: assert property (s_rd(8'h17) |=> reg_rdata == $past(scratch_r))
        else $error("Scratch set alias read wrong.");

    scratch_free_a: assert property (s_scratch_wr |=> $stable({pulldown_r, rise_en_r, fall_en_r}))
        else $error("Scratch write changed a control register.");

endmodule : pod_regs

// ---- pod_regs_test.sv ----
// Self-checking bench for the line pull-down and detach interrupt register bank.
`timescale 1ns/1ps
module pod_regs_test
    import pod_pkg::*;
;
    logic       core_clk;
    logic       nrst;
    logic [7:0] reg_addr;
    logic [7:0] reg_wdata;
    logic       reg_wr;
    logic       reg_rd;
    logic [7:0] reg_rdata;
    logic       far_detach_in;
    logic [1:0] line_level_in;
    logic       pos_line_pulldown_en;
    logic       neg_line_pulldown_en;
    logic       detach_irq_latched;
    int         miscompares;
    int         n_checks;
    logic [7:0] en_base [2];

    pod_regs dut (.core_clk(core_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .far_detach_in(far_detach_in),
        .line_level_in(line_level_in), .pos_line_pulldown_en(pos_line_pulldown_en),
        .neg_line_pulldown_en(neg_line_pulldown_en), .detach_irq_latched(detach_irq_latched));

    pod_link_model link (.core_clk(core_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

    initial core_clk = 1'b0;
    always #12.5 core_clk = ~core_clk;

    task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_checks++;
        if (g !== e) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk8

    task automatic chk1(input string nm, input logic e, input logic g);
        n_checks++;
        if (g !== e) begin
            miscompares++;
            $display("[FAIL] %s expected %b seen %b", nm, e, g);
        end
    endtask : chk1

    task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        link.rd(a, d);
        chk8($sformatf("reg_%h", a), e, d);
    endtask : rdchk

    // Five edges cover the two synchroniser stages, the edge detect and the latch update.
    task automatic pin(input logic v);
        far_detach_in <= v;
        repeat (5) @(posedge core_clk);
    endtask : pin

    task automatic close_out;
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : close_out

    initial begin
        repeat (20000) @(posedge core_clk);
        miscompares++;
        close_out();
    end

    initial begin
        miscompares = 0;
        n_checks = 0;
        en_base = '{POD_RISE_EN_OFS, POD_FALL_EN_OFS};
        nrst = 1'b0;
        far_detach_in = 1'b0;
        line_level_in = 2'b00;
        repeat (5) @(posedge core_clk);
        nrst <= 1'b1;
        @(posedge core_clk);
        chk1("pos_pd", 1'b1, pos_line_pulldown_en); // reset on
        chk1("neg_pd", 1'b1, neg_line_pulldown_en); // reset on
        for (int i = 0; i < 3; i++) begin
            rdchk(POD_PULLDOWN_OFS + 8'(i), 8'h06); // alias
            rdchk(POD_RISE_EN_OFS + 8'(i), 8'h01); // alias
            rdchk(POD_FALL_EN_OFS + 8'(i), 8'h01); // alias
            rdchk(POD_SCRATCH_OFS + 8'(i), 8'h00); // alias
        end
        rdchk(POD_STATUS_OFS, 8'h00); // idle status
        rdchk(POD_LATCH_OFS, 8'h00); // idle latch
        rdchk(8'h20, 8'h00);
        @(posedge core_clk);
        chk8("rdata_idle", 8'h00, reg_rdata);
        $display("test reset done");
        link.wr(POD_PULLDOWN_OFS, 8'hFF);
        rdchk(POD_PULLDOWN_OFS + 8'h02, 8'h06); // masked
        link.wr(POD_PULLDOWN_OFS + 8'h02, 8'h02);
        rdchk(POD_PULLDOWN_OFS + 8'h01, 8'h04); // clear
        chk1("pos_pd", 1'b0, pos_line_pulldown_en); // off
        chk1("neg_pd", 1'b1, neg_line_pulldown_en); // kept
        link.wr(POD_PULLDOWN_OFS + 8'h01, 8'h02);
        rdchk(POD_PULLDOWN_OFS, 8'h06); // set
        link.wr(POD_PULLDOWN_OFS, 8'h02);
        chk1("neg_pd", 1'b0, neg_line_pulldown_en); // off
        link.wr(POD_PULLDOWN_OFS + 8'h01, 8'h04);
        $display("test pulldown done");
        link.wr(POD_SCRATCH_OFS, 8'hA5);
        rdchk(POD_SCRATCH_OFS + 8'h01, 8'hA5); // write
        link.wr(POD_SCRATCH_OFS + 8'h01, 8'h0F);
        rdchk(POD_SCRATCH_OFS + 8'h02, 8'hAF); // set
        link.wr(POD_SCRATCH_OFS + 8'h02, 8'hA0);
        rdchk(POD_SCRATCH_OFS, 8'h0F); // clear
        link.wr(POD_SCRATCH_OFS, 8'h3C);
        rdchk(POD_SCRATCH_OFS + 8'h02, 8'h3C); // clear alias
        rdchk(POD_PULLDOWN_OFS, 8'h06); // no effect
        $display("test scratch done");
        foreach (en_base[k]) begin
            link.wr(en_base[k], 8'hFE);
            rdchk(en_base[k], 8'h00); // write
            link.wr(en_base[k] + 8'h01, 8'hFF);
            rdchk(en_base[k] + 8'h02, 8'h01); // set
            link.wr(en_base[k] + 8'h02, 8'h01);
            rdchk(en_base[k] + 8'h01, 8'h00); // clear
            link.wr(en_base[k] + 8'h01, 8'h01);
        end
        $display("test enables done");
        pin(1'b1);
        chk1("latched", 1'b1, detach_irq_latched); // rise
        rdchk(POD_STATUS_OFS, 8'h01); // status
        rdchk(POD_LATCH_OFS, 8'h01); // read
        rdchk(POD_LATCH_OFS, 8'h00); // cleared
        // The fall pulse meets the latch read at the same edge.
        far_detach_in <= 1'b0;
        repeat (2) @(posedge core_clk);
        rdchk(POD_LATCH_OFS, 8'h00); // set wins
        pin(1'b0);
        rdchk(POD_LATCH_OFS, 8'h01); // fall
        rdchk(POD_STATUS_OFS, 8'h00); // low
        link.wr(POD_RISE_EN_OFS + 8'h02, 8'h01);
        pin(1'b1);
        rdchk(POD_LATCH_OFS, 8'h00); // masked
        link.wr(POD_RISE_EN_OFS + 8'h01, 8'h01);
        link.wr(POD_FALL_EN_OFS + 8'h02, 8'h01);
        pin(1'b0);
        rdchk(POD_LATCH_OFS, 8'h00); // masked
        link.wr(POD_FALL_EN_OFS + 8'h01, 8'h01);
        link.wr(POD_PULLDOWN_OFS + 8'h02, 8'h02);
        pin(1'b1);
        rdchk(POD_STATUS_OFS, 8'h00); // not host
        pin(1'b0);
        rdchk(POD_LATCH_OFS, 8'h00); // not host
        link.wr(POD_STATUS_OFS, 8'hFF);
        rdchk(POD_STATUS_OFS, 8'h00); // read only
        $display("test detach done");
        for (int v = 0; v < 4; v++) begin
            line_level_in <= 2'(v);
            repeat (3) @(posedge core_clk);
            rdchk(POD_DEBUG_OFS, 8'(v)); // mirror
        end
        $display("test debug done");
        nrst <= 1'b0;
        @(posedge core_clk);
        nrst <= 1'b1;
        @(posedge core_clk);
        rdchk(POD_SCRATCH_OFS, 8'h00); // reset zero
        rdchk(POD_PULLDOWN_OFS, 8'h06); // reset
        $display("test rereset done");
        close_out();
    end
endmodule : pod_regs_test

// ---- pod_sync_edge.sv ----
// Two-stage pin synchroniser with rise and fall pulses per bit.
`timescale 1ns/1ps
module pod_sync_edge
    import pod_pkg::*;
#(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input  wire logic             core_clk,
    input  wire logic             nrst,
    // Asynchronous pin levels
    input  wire logic [WIDTH-1:0] async_in,
    // Synchronised level and edge pulses
    output logic      [WIDTH-1:0] level,
    output logic      [WIDTH-1:0] rise,
    output logic      [WIDTH-1:0] fall
);

    genvar gi;
    generate
        for (gi = 0; gi < WIDTH; gi++) begin : g_bit
            logic meta_r;
            logic sync_r;
            logic prev_r;

            // The first stage is read only by the second stage, so metastability never reaches the edge logic.
            always_ff @(posedge core_clk or negedge nrst) begin
                if (!nrst) begin
                    meta_r <= 1'b0;
                    sync_r <= 1'b0;
                    prev_r <= 1'b0;
                end else begin
                    meta_r <= async_in[gi];
                    sync_r <= meta_r;
                    prev_r <= sync_r;
                end
            end

            assign level[gi] = sync_r;
            assign rise[gi]  = sync_r & ~prev_r;
            assign fall[gi]  = ~sync_r & prev_r;
        end
    endgenerate

endmodule : pod_sync_edge
